/* shared/php_pkg.sv */
// Package of constants and types shared by both ends of the parallel host register port.
//----------------------------------------------------------------------
// Summary of operation
// - Strap low asynchronous, high synchronous timing.
// - Synchronous mode times accesses on host clock.
// - Eight-bit address selects exactly one register.
// - Device drives data on reads, samples writes.
// - No access while chip select is high.
// - Read strobe low starts read, drives data.
// - Write strobe low starts write, captures data.
// - Read ready low once data is valid.
// - Write ready low only after data stored.
// - Host gives address and select before strobes.
// - Host holds read strobe until ready seen.
// - Host drives write data before write strobe.
// - Host raises select between every access.
// - Interrupt low on alarm change, clear-on-read releases.
// - Reset input low returns device to reset.
// - Synchronous ready within two clocks plus 5 ns.
//----------------------------------------------------------------------
package php_pkg;

   //----------------------------------------------------------------------
   // Widths and map.
   //----------------------------------------------------------------------
   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned NUM_REGS    = 256;
   localparam logic [7:0]  ALARM_ADDR  = 8'h02;   // Clear-on-read alarm status register.
   localparam logic [7:0]  STATUS_ADDR = 8'h03;   // Live alarm level register, read only.
   localparam logic [7:0]  CTRL_ADDR   = 8'h04;   // Control byte handed to the line side.
   localparam logic [7:0]  RESET_VAL   = 8'h00;

   //----------------------------------------------------------------------
   // Timing.
   //----------------------------------------------------------------------
   localparam int unsigned PCLK_MIN_NS    = 15;
   localparam int unsigned SYNC_EXTRA_NS  = 5;
   localparam int unsigned SYNC_RDY_CLKS  = 2;
   localparam int unsigned HOST_CLK_NS    = 100;
   localparam int unsigned HOST_DIV       = 3;    // Host link clock is core clock over 2*DIV.

   typedef enum logic [1:0] {
      PHP_IDLE  = 2'b00,
      PHP_ACT   = 2'b01,
      PHP_DONE  = 2'b10,
      PHP_CLOSE = 2'b11
   } php_state_t;

endpackage

/* shared/php_if.sv */
// Interface carrying the parallel host port pins between host and device.
interface php_if;
   logic       pclk;        // Host bus clock, made by the host.
   logic       mode_sync;   // Strap: 0 asynchronous, 1 synchronous.
   logic [7:0] addr;
   logic [7:0] d_host;
   logic       d_host_oe;
   logic [7:0] d_dev;
   logic       d_dev_oe;
   logic       cs_n;
   logic       rd_n;
   logic       wr_n;
   logic       rdy_n;
   logic       int_n;
   logic       rst_n;
   logic [7:0] d_bus;

   // Resolved data bus: device drive wins over host drive, else pulled high.
   assign d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hff);

   modport device (input pclk, mode_sync, addr, d_bus, cs_n, rd_n, wr_n, rst_n,
                   output d_dev, d_dev_oe, rdy_n, int_n);
   modport host   (output pclk, mode_sync, addr, d_host, d_host_oe, cs_n, rd_n, wr_n, rst_n,
                   input d_bus, rdy_n, int_n);
endinterface

/* verilog/php_device.sv */
// Device end: register file behind the parallel host port, clocked by the host bus clock.
module php_device
   import php_pkg::*;
(
   php_if.device              bus,
   input  wire logic [7:0]    alarm_i,     // Live alarm levels from the line side, pclk domain.
   output logic [7:0]         ctrl_reg_o   // Register 0x04 contents for the line side.
);

   //----------------------------------------------------------------------
   // State.
   //----------------------------------------------------------------------
   typedef struct packed {
      php_state_t  st;
      logic [7:0]  rdata;
      logic        oe;
      logic        rdy;
      logic [7:0]  alarm_prev;
      logic [7:0]  alarm_stk;
   } php_dev_t;

   php_dev_t   s_q;
   php_dev_t   s_d;
   logic [7:0] regs_q [NUM_REGS];
   logic       wr_en;
   logic       async_mode;

   // Asynchronous mode still runs on pclk here; only response latency differs.
   assign async_mode = ~bus.mode_sync;

   // Write happens on the same edge the strobe is seen, so ready follows a stored value.
   always_comb begin
      s_d   = s_q;
      wr_en = 1'b0;
      s_d.alarm_prev = alarm_i;
      s_d.alarm_stk  = s_q.alarm_stk | (alarm_i ^ s_q.alarm_prev);
      unique case (s_q.st)
         PHP_IDLE: begin
            if (!bus.cs_n && !bus.rd_n) begin
               s_d.rdata = (bus.addr == ALARM_ADDR) ? s_q.alarm_stk :
                           (bus.addr == STATUS_ADDR) ? alarm_i : regs_q[bus.addr];
               s_d.oe = 1'b1;
               s_d.st = async_mode ? PHP_ACT : PHP_DONE;
               if (bus.addr == ALARM_ADDR) begin
                  // New changes in this cycle survive the clear.
                  s_d.alarm_stk = alarm_i ^ s_q.alarm_prev;
               end
            end else if (!bus.cs_n && !bus.wr_n) begin
               wr_en = 1'b1;
               s_d.st = async_mode ? PHP_ACT : PHP_DONE;
            end
         end
         PHP_ACT: begin
            s_d.st = PHP_DONE;
         end
         PHP_DONE: begin
            s_d.rdy = 1'b1;
            s_d.st  = PHP_CLOSE;
         end
         PHP_CLOSE: begin
            s_d.st = PHP_CLOSE;
         end
      endcase
      // Strobe release or deselect ends any cycle.
      if (s_q.st != PHP_IDLE && (bus.cs_n || (bus.rd_n && bus.wr_n))) begin
         s_d.st  = PHP_IDLE;
         s_d.oe  = 1'b0;
         s_d.rdy = 1'b0;
      end
   end

   // Pin reset is synchronous to pclk in this implementation.
   always_ff @(posedge bus.pclk) begin
      if (!bus.rst_n) begin
         s_q <= '{st: PHP_IDLE, rdata: RESET_VAL, oe: 1'b0, rdy: 1'b0,
                  alarm_prev: RESET_VAL, alarm_stk: RESET_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   // Register array, written only by the host.
   always_ff @(posedge bus.pclk) begin
      if (!bus.rst_n) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= RESET_VAL;
         end
      end else if (wr_en) begin
         regs_q[bus.addr] <= bus.d_bus;
      end
   end

   assign bus.d_dev    = s_q.rdata;
   assign bus.d_dev_oe = s_q.oe;
   assign bus.rdy_n    = ~s_q.rdy;
   assign bus.int_n    = ~|s_q.alarm_stk;
   assign ctrl_reg_o   = regs_q[CTRL_ADDR];

endmodule

/* verilog/php_host.sv */
// Host end: runs single register accesses on the port from a core-clock command.
module php_host
   import php_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        srst_i,
   input  wire logic        sync_mode_i,   // Strap level driven to the device.
   input  wire logic        req_i,         // Pulse: start an access.
   input  wire logic        we_i,
   input  wire logic [7:0]  addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic             busy_o,
   output logic             done_o,        // Pulse when the access closes.
   output logic [7:0]       rdata_o,
   output logic             irq_o,
   php_if.host              bus
);

   typedef enum logic [2:0] {
      H_IDLE = 3'b000, H_SEL = 3'b001, H_STB = 3'b010, H_WAIT = 3'b011, H_END = 3'b100
   } php_hst_t;

   typedef struct packed {
      php_hst_t    st;
      logic [2:0]  div;
      logic        pclk;
      logic        we;
      logic [7:0]  addr;
      logic [7:0]  wdata;
      logic [7:0]  rdata;
      logic        cs;
      logic        stb;
      logic        doe;
      logic        done;
      logic [1:0]  rdy_sync;
      logic [1:0]  int_sync;
      logic        lrst_n;
   } php_h_t;

   php_h_t s_q;
   php_h_t s_d;
   logic   tick;

   // Select, strobe and data drive move only on pclk falling edges so the device sees them settled; address loads on the request.
   assign tick = (s_q.div == 3'(HOST_DIV - 1)) && s_q.pclk;

   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.rdy_sync = {s_q.rdy_sync[0], ~bus.rdy_n};
      s_d.int_sync = {s_q.int_sync[0], ~bus.int_n};
      s_d.div  = (s_q.div == 3'(HOST_DIV - 1)) ? 3'h0 : s_q.div + 3'h1;
      if (s_q.div == 3'(HOST_DIV - 1)) begin
         s_d.pclk = ~s_q.pclk;
      end
      // The device resets on the link clock, which stands still in core reset, so its
      // reset is held low until one link clock rise has passed after release.
      s_d.lrst_n = s_q.lrst_n | s_q.pclk;
      unique case (s_q.st)
         H_IDLE: if (req_i) begin
            s_d.st    = H_SEL;
            s_d.we    = we_i;
            s_d.addr  = addr_i;
            s_d.wdata = wdata_i;
         end
         H_SEL: if (tick) begin
            s_d.cs  = 1'b1;
            s_d.doe = s_q.we;
            s_d.st  = H_STB;
         end
         H_STB: if (tick) begin
            s_d.stb = 1'b1;
            s_d.st  = H_WAIT;
         end
         H_WAIT: if (s_q.rdy_sync[1] && tick) begin
            s_d.rdata = s_q.we ? s_q.rdata : bus.d_bus;
            s_d.stb   = 1'b0;
            s_d.st    = H_END;
         end
         H_END: if (tick) begin
            s_d.cs   = 1'b0;
            s_d.doe  = 1'b0;
            s_d.done = 1'b1;
            s_d.st   = H_IDLE;
         end
         default: s_d.st = H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         s_q <= '{st: H_IDLE, div: 3'h0, pclk: 1'b0, we: 1'b0, addr: 8'h00, wdata: 8'h00,
                  rdata: 8'h00, cs: 1'b0, stb: 1'b0, doe: 1'b0, done: 1'b0,
                  rdy_sync: 2'b00, int_sync: 2'b00, lrst_n: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.pclk      = s_q.pclk;
   assign bus.mode_sync = sync_mode_i;
   assign bus.rst_n     = s_q.lrst_n;
   assign bus.addr      = s_q.addr;
   assign bus.d_host    = s_q.wdata;
   assign bus.d_host_oe = s_q.doe;
   assign bus.cs_n      = ~s_q.cs;
   assign bus.rd_n      = ~(s_q.stb & ~s_q.we);
   assign bus.wr_n      = ~(s_q.stb & s_q.we);
   assign busy_o        = (s_q.st != H_IDLE);
   assign done_o        = s_q.done;
   assign rdata_o       = s_q.rdata;
   assign irq_o         = s_q.int_sync[1];

endmodule

/* tb/php_asserts.sv */
// Checker of the parallel host port pins, clocked by the host bus clock.
module php_asserts (
   input wire logic pclk,
   input wire logic mode_sync,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic rdy_n,
   input wire logic d_dev_oe,
   input wire logic int_n,
   input wire logic rst_n
);
   timeunit 1ns;
   timeprecision 1ns;
   //----------------------------------------------------------------------
   // Port rules
   //----------------------------------------------------------------------
   logic st;
   // A strobe only counts while the port is selected, so a stray strobe is ignored.
   assign st = !cs_n && !(rd_n && wr_n);
   default clocking @(posedge pclk); endclocking
   default disable iff (!rst_n);
   a_rdy_sync_time:
   assert property ($rose(st) && mode_sync |-> ##[1:2] !rdy_n) else $error("sync ready late");
   a_rdy_async_time:
   assert property ($rose(st) && !mode_sync |-> ##[2:3] !rdy_n) else $error("async ready off");
   a_no_early_rdy:
   assert property ($rose(st) |-> rdy_n) else $error("ready before access taken");
   a_rdy_release:
   assert property (!rdy_n && (cs_n || (rd_n && wr_n)) |=> rdy_n) else $error("ready stuck");
   a_oe_release:
   assert property (d_dev_oe && (cs_n || rd_n) |=> !d_dev_oe) else $error("data drive stuck");
   a_idle_quiet:
   assert property (cs_n && $past(cs_n) |-> rdy_n && !d_dev_oe) else $error("active unselected");
   a_read_data:
   assert property (!rdy_n && !cs_n && !rd_n |-> d_dev_oe) else $error("read ready, no data");
   a_write_input:
   assert property (!cs_n && !wr_n |-> !d_dev_oe) else $error("device drives in write");
   a_reset_idle:
   assert property ($rose(rst_n) |-> rdy_n && int_n) else $error("outputs not idle at reset");
   cover property ($rose(st) && !rd_n);
   cover property ($rose(st) && !wr_n);
   cover property ($fell(int_n));
endmodule

/* tb/tb_top.sv */
// Testbench joining host and device ends of the parallel host port.
module tb_top import php_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   //----------------------------------------------------------------------
   // Ends and checker
   //----------------------------------------------------------------------
   logic       core_clk_i, srst_i, sync_mode_i, req_i, we_i, busy_o, done_o, irq_o;
   logic [7:0] addr_i, wdata_i, rdata_o, alarm_i, ctrl_reg_o, d;
   logic [8:0] note;
   logic [8:0] exp_q[$];
   int         errors, comparisons, cycles;
   php_if php_if_inst ();
   php_host php_host_inst (.core_clk_i, .srst_i, .sync_mode_i, .req_i, .we_i, .addr_i,
      .wdata_i, .busy_o, .done_o, .rdata_o, .irq_o, .bus(php_if_inst));
   php_device php_device_inst (.bus(php_if_inst), .alarm_i, .ctrl_reg_o);
   php_asserts php_asserts_inst (.pclk(php_if_inst.pclk), .mode_sync(php_if_inst.mode_sync),
      .cs_n(php_if_inst.cs_n), .rd_n(php_if_inst.rd_n), .wr_n(php_if_inst.wr_n),
      .rdy_n(php_if_inst.rdy_n), .d_dev_oe(php_if_inst.d_dev_oe),
      .int_n(php_if_inst.int_n), .rst_n(php_if_inst.rst_n));
   //----------------------------------------------------------------------
   // Tasks
   //----------------------------------------------------------------------
   task chk(input logic [7:0] seen, input logic [7:0] want);
      comparisons++;
      if (seen !== want) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task complete_run();
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Request is held a second cycle on purpose: a busy host must not start twice.
   task acc(input logic w, input logic [7:0] ad, input logic [7:0] dd, input logic [7:0] ed);
      exp_q.push_back({w, ed});
      we_i <= w;
      addr_i <= ad;
      wdata_i <= dd;
      req_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      req_i <= 1'b0;
      chk({7'h00, busy_o}, 8'h01);
      while (done_o !== 1'b1) @(posedge core_clk_i);
      @(posedge core_clk_i);
      chk({7'h00, busy_o}, 8'h00);
   endtask
   task wait_irq(input logic v);
      int n;
      n = 0;
      while (irq_o !== v && n < 300) begin
         @(posedge core_clk_i);
         n++;
      end
      chk({7'h00, irq_o}, {7'h00, v});
   endtask
   //----------------------------------------------------------------------
   // Clock, watchdog and result monitor
   //----------------------------------------------------------------------
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = !core_clk_i;
   end
   // Each access spans a few link clocks; the ceiling leaves ample margin.
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         complete_run();
      end
   end
   always @(posedge core_clk_i) begin
      if (done_o === 1'b1) begin
         chk(8'(exp_q.size()), 8'h01);
         note = exp_q.pop_front();
         if (!note[8]) chk(rdata_o, note[7:0]);
      end
   end
   //----------------------------------------------------------------------
   // Scenarios
   //----------------------------------------------------------------------
   initial begin
      {srst_i, sync_mode_i, req_i, we_i, addr_i, wdata_i, alarm_i} = {4'b1100, 24'h0};
      void'($urandom(73));
      repeat (12) @(posedge core_clk_i);
      srst_i <= 1'b0;
      @(posedge core_clk_i);
      // Write then read back random places, first synchronous then asynchronous strap.
      for (int m = 0; m < 2; m++) begin
         sync_mode_i <= (m == 0);
         repeat (20) @(posedge core_clk_i);
         for (int i = 0; i < 6; i++) begin
            addr_i <= 8'h10 + 8'($urandom % 240);
            d = 8'($urandom);
            @(posedge core_clk_i);
            acc(1'b1, addr_i, d, 8'h00);
            acc(1'b0, addr_i, 8'h00, d);
         end
      end
      d = 8'($urandom);
      acc(1'b1, CTRL_ADDR, d, 8'h00);
      chk(ctrl_reg_o, d);
      srst_i <= 1'b1;
      repeat (12) @(posedge core_clk_i);
      srst_i <= 1'b0;
      @(posedge core_clk_i);
      acc(1'b0, CTRL_ADDR, 8'h00, RESET_VAL);
      chk(ctrl_reg_o, RESET_VAL);
      // Alarm levels belong to the link domain, so they change away from its sampling edge.
      @(negedge php_if_inst.pclk) alarm_i <= 8'h5a;
      wait_irq(1'b1);
      acc(1'b0, STATUS_ADDR, 8'h00, 8'h5a);
      acc(1'b0, ALARM_ADDR, 8'h00, 8'h5a);
      wait_irq(1'b0);
      acc(1'b0, ALARM_ADDR, 8'h00, 8'h00);
      repeat (10) @(posedge core_clk_i);
      complete_run();
   end
endmodule
